/* design/bpi_backplane_glue.v */
// Overview of operation
// - Take three backplane, four header requests.
// - Two cascaded banks give fifteen vectored inputs.
// - Never drive cascade address during acknowledge.
// - Backplane requests share lines five, ten, fifteen.
// - Disk, video front lines hit dedicated inputs.
// - Width response low selects sixteen-bit transfer.
// - No width response means eight-bit transfer.
// - Present ten-bit port addresses on backplane.
// - Option drives extend strobe for 100-1FF.
// - Drive add-on bus, or route via backplane.
// - Supply fault asserts reset, blocks write strobe.
`include "bpi_defines.vh"

module bpi_backplane_glue (
    input wire core_clk,
    input wire sys_rst,
    input wire backplane_irq_a_n,
    input wire backplane_irq_b_n,
    input wire backplane_irq_c_n,
    input wire [3:0] headerIrq,
    input wire fixedDiskIrq,
    input wire diskIrq,
    input wire videoIrq,
    input wire [15:0] onboardIrq,
    input wire addonBusEnable,
    input wire [7:0] masterMask,
    input wire [7:0] slaveMask,
    input wire intAck,
    output reg intReq,
    output reg [7:0] intVector,
    output wire cascadeOe,
    output reg [15:0] addonIrqBus,
    input wire parityError,
    output reg nmiReq,
    input wire cycleStart,
    input wire cycleIsMemory,
    input wire memory_wide_ack_n,
    input wire port_wide_ack_n,
    output reg wideTransfer,
    input wire [15:0] cpuPortAddr,
    input wire portCycle,
    input wire extendEnable,
    output reg [9:0] backplanePortAddr,
    output reg port_space_extend_n,
    input wire supplyFault,
    input wire cpuWrite_n,
    output reg board_reset_n,
    output reg busWrite_n
);
    // ----------------------------------------------------------------
    // Request routing.
    // ----------------------------------------------------------------
    reg [15:0] irqLines;
    wire [2:0] masterLevel;
    wire [2:0] slaveLevel;
    wire masterPending;
    wire slavePending;
    wire masterAck;
    wire slaveAck;
    wire [7:0] masterService;
    wire [7:0] slaveService;

    always @* begin
        irqLines = onboardIrq;
        irqLines[0] = onboardIrq[0];
        irqLines[`BPI_IRQ_CASCADE] = 1'b0;
        irqLines[`BPI_IRQ_DISK] = fixedDiskIrq | ~backplane_irq_a_n;
        irqLines[`BPI_IRQ_HEADER_A] = headerIrq[0] | ~backplane_irq_b_n;
        irqLines[`BPI_IRQ_HEADER_B] = headerIrq[1];
        irqLines[`BPI_IRQ_HEADER_C] = headerIrq[2];
        irqLines[`BPI_IRQ_HEADER_D] = headerIrq[3] | ~backplane_irq_c_n;
        irqLines[`BPI_IRQ_HARD_DISK] = onboardIrq[`BPI_IRQ_HARD_DISK] | diskIrq;
        irqLines[`BPI_IRQ_VIDEO] = onboardIrq[`BPI_IRQ_VIDEO] | videoIrq;
        if (!addonBusEnable) begin
            irqLines[`BPI_IRQ_DISK] = irqLines[`BPI_IRQ_DISK] | fixedDiskIrq;
        end
    end

    // ----------------------------------------------------------------
    // Cascaded controllers.
    // ----------------------------------------------------------------
    bpi_irq_bank slaveBank (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .requestIn(irqLines[15:8]),
        .maskBits(slaveMask),
        .ackPulse(slaveAck),
        .pending(slavePending),
        .topLevel(slaveLevel),
        .inService(slaveService)
    );

    bpi_irq_bank masterBank (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .requestIn({irqLines[7:3], slavePending, irqLines[1:0]}),
        .maskBits(masterMask),
        .ackPulse(masterAck),
        .pending(masterPending),
        .topLevel(masterLevel),
        .inService(masterService)
    );

    reg ackSeen;
    assign masterAck = intAck & ~ackSeen;
    assign slaveAck = masterAck & (masterLevel == 3'h2);
    assign cascadeOe = 1'b0;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackSeen <= 1'b0;
            intReq <= 1'b0;
            intVector <= `BPI_VECTOR_RESET;
            nmiReq <= 1'b0;
            addonIrqBus <= 16'h0000;
        end else begin
            ackSeen <= intAck;
            intReq <= masterPending;
            nmiReq <= parityError;
            addonIrqBus <= addonBusEnable ? irqLines : 16'h0000;
            if (masterAck) begin
                if (masterLevel == 3'h2) begin
                    intVector <= {5'h01, slaveLevel};
                end else begin
                    intVector <= {5'h00, masterLevel};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus sizing, port decode and supply supervision.
    // ----------------------------------------------------------------
    wire widthAck;
    wire inExtend;
    assign widthAck = cycleIsMemory ? ~memory_wide_ack_n : ~port_wide_ack_n;
    assign inExtend = (cpuPortAddr[9:0] >= `BPI_EXT_LOW) && (cpuPortAddr[9:0] <= `BPI_EXT_HIGH);

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wideTransfer <= 1'b0;
            backplanePortAddr <= 10'h000;
            port_space_extend_n <= 1'b1;
            board_reset_n <= 1'b0;
            busWrite_n <= 1'b1;
        end else begin
            if (cycleStart) begin
                wideTransfer <= widthAck;
            end
            backplanePortAddr <= cpuPortAddr[9:0];
            port_space_extend_n <= ~(extendEnable & portCycle & inExtend);
            board_reset_n <= ~supplyFault;
            busWrite_n <= cpuWrite_n | supplyFault;
        end
    end
endmodule // bpi_backplane_glue

/* design/bpi_defines.vh */
`ifndef BPI_DEFINES_VH
`define BPI_DEFINES_VH

// Interrupt request lines of the controller pair.
`define BPI_IRQ_COUNT 16
`define BPI_IRQ_CASCADE 2
`define BPI_IRQ_DISK 5
`define BPI_IRQ_VIDEO 9
`define BPI_IRQ_HEADER_A 10
`define BPI_IRQ_HEADER_B 11
`define BPI_IRQ_HEADER_C 12
`define BPI_IRQ_HARD_DISK 14
`define BPI_IRQ_HEADER_D 15
`define BPI_HEADER_COUNT 4

// Port address decode.
`define BPI_PORT_ADDR_W 10
`define BPI_EXT_LOW 10'h100
`define BPI_EXT_HIGH 10'h1ff

// Controller bank state.
`define BPI_SLAVE_BASE 8
`define BPI_VECTOR_RESET 8'h00

`endif

/* design/bpi_irq_bank.v */
`include "bpi_defines.vh"

// --------------------------------------------------------------------
// Eight-input prioritized, maskable request bank.
// --------------------------------------------------------------------
module bpi_irq_bank (
    input wire core_clk,
    input wire sys_rst,
    input wire [7:0] requestIn,
    input wire [7:0] maskBits,
    input wire ackPulse,
    output wire pending,
    output reg [2:0] topLevel,
    output reg [7:0] inService
);
    reg [7:0] latched;
    reg [7:0] active;
    reg [2:0] next_level;
    reg found;
    integer i;

    // The lowest numbered unmasked request wins.
    always @* begin
        next_level = 3'h0;
        found = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            if (active[i]) begin
                next_level = i[2:0];
                found = 1'b1;
            end
        end
    end

    always @* begin
        active = latched & ~maskBits & ~inService;
    end

    assign pending = found;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            latched <= 8'h00;
            inService <= 8'h00;
            topLevel <= 3'h0;
        end else begin
            topLevel <= next_level;
            if (ackPulse && found) begin
                latched <= (latched | requestIn) & ~(8'h01 << next_level);
                inService <= inService | (8'h01 << next_level);
            end else begin
                latched <= latched | (requestIn & ~inService);
                inService <= inService & requestIn;
            end
        end
    end
endmodule // bpi_irq_bank

/* verif/bpi_backplane_glue_bench.sv */
module bpi_backplane_glue_bench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, a) begin checkCount++; if ((a) !== (e)) begin nErrors++; $display("[FAIL] %s %0h %0h", n, e, a); end end
    logic core_clk = 0, sys_rst = 1, addonBusEnable = 0, intAck = 0, parityError = 0, cycleStart = 0;
    logic cycleIsMemory = 0, wideCard = 0, portCycle = 0, extendEnable = 0, supplyFault = 0, cpuWrite_n = 1;
    logic [9:0] src = 0;
    logic [7:0] masterMask = 0;
    logic [15:0] cpuPortAddr = 0;
    wire backplane_irq_a_n, backplane_irq_b_n, backplane_irq_c_n, memory_wide_ack_n, port_wide_ack_n;
    wire intReq, cascadeOe, nmiReq, wideTransfer, port_space_extend_n, board_reset_n, busWrite_n;
    wire [7:0] intVector;
    wire [15:0] addonIrqBus;
    wire [9:0] backplanePortAddr;
    int nErrors = 0, checkCount = 0;
    always #10 core_clk = ~core_clk;
    bpi_card_model card (.irqReq(src[2:0]), .*);
    bpi_backplane_glue dut (.headerIrq(src[6:3]), .fixedDiskIrq(src[7]), .diskIrq(src[8]), .videoIrq(src[9]),
        .onboardIrq(16'h0000), .slaveMask(8'h00), .*);
    task automatic wait1(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic irqRoute();
        int lineNo[10] = '{5, 10, 15, 10, 11, 12, 15, 5, 14, 9};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            src <= 10'h001 << i;
            wait1(3);
            `CHK("req", 1'b1, intReq)
            `CHK("addon", 1'b1, addonIrqBus[lineNo[i]])
            @(posedge core_clk);
            intAck <= 1;
            wait1(2);
            `CHK("vec", lineNo[i], intVector)
            `CHK("casc", 1'b0, cascadeOe)
            @(posedge core_clk);
            intAck <= 0;
            src <= 0;
            wait1(3);
        end
    endtask
    task automatic irqMask();
        @(posedge core_clk);
        masterMask <= 8'h20;
        addonBusEnable <= 0;
        src <= 10'h001;
        wait1(3);
        `CHK("masked", 1'b0, intReq)
        `CHK("addonOff", 16'h0000, addonIrqBus)
        @(posedge core_clk);
        src <= 0;
        masterMask <= 0;
    endtask
    task automatic width(input logic mem, input logic wide);
        @(posedge core_clk);
        cycleStart <= 1;
        cycleIsMemory <= mem;
        wideCard <= wide;
        @(posedge core_clk);
        cycleStart <= 0;
        #1;
        `CHK("wide", wide, wideTransfer)
    endtask
    task automatic portAccess(input logic [15:0] a, input logic en);
        @(posedge core_clk);
        portCycle <= 1;
        cpuPortAddr <= a;
        extendEnable <= en;
        @(posedge core_clk);
        portCycle <= 0;
        #1;
        `CHK("addr", a[9:0], backplanePortAddr)
        `CHK("ext", !(en && a[9:8] == 2'h1), port_space_extend_n)
    endtask
    task automatic fault();
        @(posedge core_clk);
        supplyFault <= 1;
        cpuWrite_n <= 0;
        parityError <= 1;
        wait1(1);
        `CHK("rst", 1'b0, board_reset_n)
        `CHK("wr", 1'b1, busWrite_n)
        `CHK("nmi", 1'b1, nmiReq)
        @(posedge core_clk);
        supplyFault <= 0;
        parityError <= 0;
        wait1(1);
        `CHK("wr", 1'b0, busWrite_n)
        `CHK("rstOff", 1'b1, board_reset_n)
        `CHK("nmi", 1'b0, nmiReq)
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", nErrors, checkCount);
        if (nErrors == 0 && checkCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 0;
        addonBusEnable <= 1;
        irqRoute();
        irqMask();
        for (int i = 0; i < 4; i++) width(i[1], i[0]);
        portAccess(16'hf0ff, 1);
        portAccess(16'h0100, 1);
        portAccess(16'h01ff, 1);
        portAccess(16'h0200, 1);
        portAccess(16'h0150, 0);
        fault();
        summarize();
    end
    initial begin
        #40000;
        nErrors++;
        summarize();
    end
endmodule // bpi_backplane_glue_bench

/* verif/bpi_card_model.sv */
module bpi_card_model (
    input wire cycleStart,
    input wire cycleIsMemory,
    input wire wideCard,
    input wire [2:0] irqReq,
    output wire memory_wide_ack_n,
    output wire port_wide_ack_n,
    output wire backplane_irq_a_n,
    output wire backplane_irq_b_n,
    output wire backplane_irq_c_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // A selected wide card pulls its width line low; a released line rests high.
    assign memory_wide_ack_n = !(wideCard && cycleStart && cycleIsMemory);
    assign port_wide_ack_n = !(wideCard && cycleStart && !cycleIsMemory);
    assign {backplane_irq_c_n, backplane_irq_b_n, backplane_irq_a_n} = ~irqReq;
endmodule // bpi_card_model

/* verif/bpi_glue_assertions.sv */
module bpi_glue_assertions (
    input wire core_clk,
    input wire sys_rst,
    input wire cascadeOe,
    input wire addonBusEnable,
    input wire [15:0] addonIrqBus,
    input wire parityError,
    input wire nmiReq,
    input wire cycleStart,
    input wire cycleIsMemory,
    input wire memory_wide_ack_n,
    input wire port_wide_ack_n,
    input wire wideTransfer,
    input wire [15:0] cpuPortAddr,
    input wire portCycle,
    input wire extendEnable,
    input wire [9:0] backplanePortAddr,
    input wire port_space_extend_n,
    input wire supplyFault,
    input wire board_reset_n,
    input wire busWrite_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire ackLow = cycleIsMemory ? !memory_wide_ack_n : !port_wide_ack_n;
    wire extHit = portCycle && extendEnable && cpuPortAddr[9:8] == 2'h1;
    casc_off_a: assert property (!cascadeOe) else $error("cascade on");
    nmi_follow_a: assert property (##1 nmiReq == $past(parityError)) else $error("nmi");
    wide_xfer_a: assert property (cycleStart && ackLow |=> wideTransfer) else $error("wide");
    narrow_xfer_a: assert property (cycleStart && !ackLow |=> !wideTransfer) else $error("narrow");
    port_addr_a: assert property (portCycle |=> backplanePortAddr == $past(cpuPortAddr[9:0])) else $error("addr");
    ext_strobe_a: assert property (##1 port_space_extend_n == !$past(extHit)) else $error("ext");
    fault_gate_a: assert property (supplyFault |=> !board_reset_n && busWrite_n) else $error("fault");
    addon_off_a: assert property (!addonBusEnable |=> addonIrqBus == 16'h0000) else $error("addon");
    cover property (cycleStart ##1 wideTransfer);
    cover property (extHit);
    cover property (supplyFault);
endmodule // bpi_glue_assertions
bind bpi_backplane_glue bpi_glue_assertions chk (.*);
